//--- inc/tss_pkg.sv
// Overview of operation
// - Selection register writes are dropped while tracing is enabled.
// - Two comparators: stop in [17:16], start in [1:0], rest zero.
// - Four comparators: stop in [19:16], start in [3:0], rest zero.
// - Eight comparators: stop in [23:16], start in [7:0], rest zero.
// - Stop bit m set makes comparator m-16 a stop resource.
// - Start bit n set makes comparator n a start resource.
// - While tracing is enabled, a selected stop match moves the start/stop state to stopped.
// - While tracing is enabled, a selected start match with no selected stop match moves the start/stop state to started.
// - Filter control bit 9 shows the start/stop state and presets it while tracing is disabled.
`default_nettype none
package tss_pkg;

  localparam int          COMP_MAX      = 8;
  // Implemented comparator count: 2, 4 or 8
  localparam int          COMP_COUNT    = 8;
  localparam logic [7:0]  COMP_MASK     = 8'((1 << COMP_COUNT) - 1);
  localparam logic [3:0]  COMP_CODE     = 4'(COMP_COUNT);

  localparam logic [11:0] ADDR_TRACE_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_FILTER_CTRL = 12'h008;
  localparam logic [11:0] ADDR_SELECT      = 12'h00C;
  localparam logic [11:0] ADDR_CAP_FOUR    = 12'h010;

  localparam int          TRACE_EN_BIT     = 0;
  localparam int          SS_STATE_BIT     = 9;
  localparam int          START_LSB        = 0;
  localparam int          STOP_LSB         = 16;
  localparam int          COMP_CNT_LSB     = 12;

  localparam logic [31:0] RESET_WORD       = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] stopSel;
    logic [7:0] startSel;
  } tss_sel_t;

  typedef enum logic [1:0] {
    SS_STOPPED = 2'b01,
    SS_STARTED = 2'b10
  } tss_state_t;

endpackage
`default_nettype wire

//--- rtl/tss_start_stop.sv
`timescale 1ns/1ps
`default_nettype none
module tss_start_stop
  import tss_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       traceEnable,
  input  wire tss_sel_t   selCfg,
  input  wire logic [7:0] compMatch,
  input  wire logic       loadEn,
  input  wire logic       loadVal,
  output logic            started
);

  tss_state_t stateQ;
  tss_state_t stateD;
  logic       stopHit;
  logic       startHit;

  assign stopHit  = |(compMatch & selCfg.stopSel & COMP_MASK);
  assign startHit = |(compMatch & selCfg.startSel & COMP_MASK);

  always_comb begin
    stateD = stateQ;
    case (stateQ)
      SS_STOPPED: begin
        if (loadEn && loadVal) begin
          stateD = SS_STARTED;
        end else if (traceEnable && startHit && !stopHit) begin
          stateD = SS_STARTED;
        end
      end
      SS_STARTED: begin
        if (loadEn && !loadVal) begin
          stateD = SS_STOPPED;
        end else if (traceEnable && stopHit) begin
          stateD = SS_STOPPED;
        end
      end
      default: begin
        stateD = SS_STOPPED;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= SS_STOPPED;
    end else begin
      stateQ <= stateD;
    end
  end

  // One-hot code: bit 1 alone marks started, so the output is a bare flop
  assign started = stateQ[1];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_stopWins;
    traceEnable && !loadEn && stopHit |=> !started;
  endproperty
  a_stopWins: assert property (p_stopWins) else $error("stop match did not stop");

  property p_startGo;
    traceEnable && !loadEn && startHit && !stopHit |=> started;
  endproperty
  a_startGo: assert property (p_startGo) else $error("start match did not start");

  property p_stopAfterStart;
    started && traceEnable && !loadEn && stopHit ##1 1 |-> !started ##1 1;
  endproperty
  a_stopAfterStart: assert property (p_stopAfterStart) else $error("started state survived stop");

  property p_load;
    loadEn |=> started == $past(loadVal);
  endproperty
  a_load: assert property (p_load) else $error("preset value not loaded");

  property p_idleHold;
    !loadEn && (!traceEnable || (!stopHit && !startHit)) |=> $stable(started);
  endproperty
  a_idleHold: assert property (p_idleHold) else $error("state moved without cause");

  c_start:    cover property (!started ##1 started);
  c_stop:     cover property (started ##1 !started);
  c_conflict: cover property (traceEnable && startHit && stopHit);

endmodule
`default_nettype wire

//--- rtl/tss_top.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tss_top
  import tss_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  compMatch,
  output logic             traceEnabled,
  output logic             traceStarted
);

  logic        preadyQ;
  logic        preadyD;
  logic [31:0] prdataQ;
  logic [31:0] prdataD;
  logic        pslverrQ;
  logic        pslverrD;
  logic        enQ;
  logic        enD;
  tss_sel_t    selQ;
  tss_sel_t    selD;
  logic        accessDone;
  logic        accessFirst;
  logic        mapped;
  logic        wrSel;
  logic        wrFilter;
  logic        ssState;

  // One wait state keeps every bus output registered
  assign accessFirst = psel && penable && !preadyQ;
  assign accessDone  = psel && penable && preadyQ;
  assign mapped      = (paddr == ADDR_TRACE_CTRL) || (paddr == ADDR_FILTER_CTRL) ||
                       (paddr == ADDR_SELECT) || (paddr == ADDR_CAP_FOUR);
  assign wrSel       = accessDone && pwrite && (paddr == ADDR_SELECT) && !enQ;
  assign wrFilter    = accessDone && pwrite && (paddr == ADDR_FILTER_CTRL) && !enQ;

  always_comb begin
    preadyD  = accessFirst;
    prdataD  = prdataQ;
    pslverrD = 1'b0;
    if (accessFirst) begin
      pslverrD = !mapped;
      prdataD  = RESET_WORD;
      if (!pwrite) begin
        case (paddr)
          ADDR_TRACE_CTRL:  prdataD[TRACE_EN_BIT] = enQ;
          ADDR_FILTER_CTRL: prdataD[SS_STATE_BIT] = ssState;
          ADDR_SELECT: begin
            prdataD[STOP_LSB +: COMP_MAX]  = selQ.stopSel & COMP_MASK;
            prdataD[START_LSB +: COMP_MAX] = selQ.startSel & COMP_MASK;
          end
          ADDR_CAP_FOUR:    prdataD[COMP_CNT_LSB +: 4] = COMP_CODE;
          default:          prdataD = RESET_WORD;
        endcase
      end
    end
  end

  always_comb begin
    enD  = enQ;
    selD = selQ;
    if (accessDone && pwrite && (paddr == ADDR_TRACE_CTRL)) begin
      enD = pwdata[TRACE_EN_BIT];
    end
    if (wrSel) begin
      // Unimplemented comparator bits are never stored
      selD.stopSel  = pwdata[STOP_LSB +: COMP_MAX] & COMP_MASK;
      selD.startSel = pwdata[START_LSB +: COMP_MAX] & COMP_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      preadyQ  <= 1'b0;
      prdataQ  <= RESET_WORD;
      pslverrQ <= 1'b0;
      enQ      <= 1'b0;
      selQ     <= '0;
    end else begin
      preadyQ  <= preadyD;
      prdataQ  <= prdataD;
      pslverrQ <= pslverrD;
      enQ      <= enD;
      selQ     <= selD;
    end
  end

  tss_start_stop u_startStop (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .traceEnable (enQ),
    .selCfg      (selQ),
    .compMatch   (compMatch),
    .loadEn      (wrFilter),
    .loadVal     (pwdata[SS_STATE_BIT]),
    .started     (ssState)
  );

  assign prdata       = prdataQ;
  assign pready       = preadyQ;
  assign pslverr      = pslverrQ;
  assign traceEnabled = enQ;
  assign traceStarted = ssState;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_wrIgnored;
    accessDone && pwrite && (paddr == ADDR_SELECT) && enQ |=> selQ == $past(selQ);
  endproperty
  a_wrIgnored: assert property (p_wrIgnored) else $error("select written while enabled");

  property p_wrTaken;
    accessDone && pwrite && (paddr == ADDR_SELECT) && !enQ
      |=> selQ.startSel == ($past(pwdata[7:0]) & COMP_MASK);
  endproperty
  a_wrTaken: assert property (p_wrTaken) else $error("select write lost");

  property p_reserved;
    ((selQ.stopSel | selQ.startSel) & ~COMP_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("unimplemented select bit set");

  property p_readState;
    accessFirst && !pwrite && (paddr == ADDR_FILTER_CTRL) |=> prdataQ[SS_STATE_BIT] == $past(ssState);
  endproperty
  a_readState: assert property (p_readState) else $error("state bit misread");

  property p_oneWait;
    accessFirst |=> preadyQ ##1 !preadyQ;
  endproperty
  a_oneWait: assert property (p_oneWait) else $error("bus answer timing wrong");

  property p_filterIgnored;
    accessDone && pwrite && (paddr == ADDR_FILTER_CTRL) && enQ &&
      !(|(compMatch & (selQ.stopSel | selQ.startSel) & COMP_MASK)) |=> $stable(ssState);
  endproperty
  a_filterIgnored: assert property (p_filterIgnored) else $error("preset written while enabled");

  property p_selReadZero;
    accessFirst && !pwrite && (paddr == ADDR_SELECT)
      |=> (prdataQ & ~{8'h00, COMP_MASK, 8'h00, COMP_MASK}) == 32'h0000_0000;
  endproperty
  a_selReadZero: assert property (p_selReadZero) else $error("reserved select bit read as one");

  property p_unmapped;
    accessFirst && !mapped |=> pslverrQ && (prdataQ == RESET_WORD);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access answered without error");

  c_selWrite: cover property (wrSel);

endmodule
`default_nettype wire

//--- dv/tss_comp_model.sv
`timescale 1ns/1ps
`default_nettype none
module tss_comp_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] hitReq,
  input  wire logic       fire,
  output logic [7:0]      compMatch
);
  // One-cycle match pulse, as a comparator hit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) compMatch <= 8'h00;
    else compMatch <= fire ? hitReq : 8'h00;
  end
endmodule
`default_nettype wire

//--- dv/test_trace_start_stop_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_trace_start_stop_select
  import tss_pkg::*;
;
  logic        mclk, rst_n, psel, penable, pwrite, fire, pready, pslverr, er;
  logic        traceEnabled, traceStarted;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  compMatch, hitReq;
  int          n_errors, cmp_count;

  tss_top u_tss_top (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compMatch(compMatch), .traceEnabled(traceEnabled), .traceStarted(traceStarted));
  tss_comp_model u_tss_comp_model (.mclk(mclk), .rst_n(rst_n), .hitReq(hitReq), .fire(fire),
    .compMatch(compMatch));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready, read data and error are all taken at the rising edge that ends the access
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) begin
        break;
      end
    end
    if (i == 20) begin
      n_errors++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic hit(input logic [7:0] p, input logic exp);
    @(posedge mclk);
    hitReq <= p; fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, traceStarted}, {31'h0, exp});
  endtask

  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; hitReq = 8'h00; fire = 1'b0; n_errors = 0; cmp_count = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_SELECT, 32'h0);
    chk(rd, RESET_WORD);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, ADDR_CAP_FOUR, 32'h0);
    chk({28'h0, rd[15:12]}, {28'h0, COMP_CODE});
    apb(1'b1, ADDR_SELECT, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_SELECT, 32'h0);
    chk(rd, {8'h00, COMP_MASK, 8'h00, COMP_MASK});
    apb(1'b0, 12'h004, 32'h0);
    chk({rd[31:1], er}, 32'h0000_0001);
    // Start on comparator 2, stop on comparator 5
    apb(1'b1, ADDR_SELECT, 32'h0020_0004);
    apb(1'b1, ADDR_FILTER_CTRL, 32'h0);
    apb(1'b1, ADDR_TRACE_CTRL, 32'h0000_0001);
    @(negedge mclk);
    chk({31'h0, traceEnabled}, 32'h1);
    apb(1'b0, ADDR_TRACE_CTRL, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b1, ADDR_FILTER_CTRL, 32'h0000_0200);
    @(negedge mclk);
    chk({31'h0, traceStarted}, 32'h0);
    apb(1'b1, ADDR_SELECT, 32'h0);
    apb(1'b0, ADDR_SELECT, 32'h0);
    chk(rd, 32'h0020_0004);
    hit(8'hDB, 1'b0);
    hit(8'h04, 1'b1);
    apb(1'b0, ADDR_FILTER_CTRL, 32'h0);
    chk({31'h0, rd[SS_STATE_BIT]}, 32'h1);
    hit(8'h20, 1'b0);
    hit(8'h04, 1'b1);
    hit(8'h24, 1'b0);
    apb(1'b1, ADDR_TRACE_CTRL, 32'h0);
    apb(1'b1, ADDR_FILTER_CTRL, 32'h0000_0200);
    @(negedge mclk);
    chk({31'h0, traceStarted}, 32'h1);
    hit(8'h20, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
